// file: src/rwie_pkg.sv
package rwie_pkg;
	// ----------------------------------------
	// reset sequencing
	// ----------------------------------------
	localparam logic [5:0]  RST_DRIVE_CYC  = 6'h22;
	localparam logic [5:0]  RST_SAMPLE_CYC = 6'h26;
	localparam logic [15:0] VEC_RESET      = 16'hFFFE;
	localparam logic [15:0] SP_RESET       = 16'h00FF;
	localparam int          CCR_I          = 3;
	localparam logic [7:0]  CCR_RESET      = 8'h08;
	localparam logic [15:0] IRQ_VEC_TOP    = 16'hFFFC;
	localparam int          IRQ_N          = 4;
	localparam int          WD_LONG_EXP    = 18;
	localparam int          WD_SHORT_EXP   = 13;
	localparam logic [2:0]  PUSH_LAST      = 3'h4;
	localparam logic [2:0]  VEC_LAST       = 3'h1;
	localparam logic [2:0]  FILL_LAST      = 3'h2;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0]  ADDR_SRS   = 8'h00;
	localparam logic [7:0]  ADDR_SYSTEM_OPTIONS_REG  = 8'h04;
	localparam logic [7:0]  ADDR_IFLAG = 8'h08;
	localparam logic [7:0]  ADDR_IEN   = 8'h0C;
	localparam int          SRS_POR    = 7;
	localparam int          SRS_PIN    = 6;
	localparam int          SRS_WD     = 5;
	localparam int          SRS_ILLOP  = 4;
	localparam int          SRS_CLK    = 2;
	localparam int          SRS_LVD    = 1;
	localparam int          SYSTEM_OPTIONS_REG_EN    = 0;
	localparam int          SYSTEM_OPTIONS_REG_TSEL  = 1;
	localparam int          SYSTEM_OPTIONS_REG_LOCK  = 2;
	localparam logic [2:0]  SYSTEM_OPTIONS_REG_RESET = 3'h3;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {S_DRIVE, S_SETTLE, S_VEC, S_FILL, S_RUN, S_PUSH, S_POP} rwie_state_e;

	// high index register deliberately absent
	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] sp;
		logic [7:0]  x;
		logic [7:0]  a;
		logic [7:0]  condition_code_reg;
	} rwie_cpu_regs_s;
endpackage

// file: src/rwie_top.sv
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Contract
// - reset loads pc from top vector, clears registers
// - reset sets global interrupt mask
// - reset forces stack pointer to fixed value
// - reset disables peripherals, pins default inputs
// - each non-debug reset source sets status bit
// - reset switches clock generator to self mode
// - drive reset pin low 34 cycles, release
// - sample pin 38 cycles later, low means pin
// - expired enabled watchdog forces system reset
// - write to status address restarts watchdog only
// - watchdog enabled after every reset
// - enable bit in write-once options register
// - timeout select chooses long or short period
// - watchdog frozen during background debug
// - event sets flag; request needs enable, unmasked
// - current instruction finishes before interrupt entry
// - entry stacks, masks, fetches vector, fills queue
// - push pcl, pch, x, a, ccr downward
// - stacked pc is next instruction address
// - return pops reverse, refills three bytes
// - high index register never stacked
// - status register shows latest reset cause
module rwie_top #(
	parameter int unsigned WD_LONG_CYC  = 1 << rwie_pkg::WD_LONG_EXP,
	parameter int unsigned WD_SHORT_CYC = 1 << rwie_pkg::WD_SHORT_EXP
) (
	input  wire logic                         i_ref_clk,
	input  wire logic                         i_sys_rst,
	input  wire logic                         i_awvalid,
	output logic                              o_awready,
	input  wire logic [7:0]                   i_awaddr,
	input  wire logic                         i_wvalid,
	output logic                              o_wready,
	input  wire logic [31:0]                  i_wdata,
	input  wire logic [3:0]                   i_wstrb,
	output logic                              o_bvalid,
	input  wire logic                         i_bready,
	output logic [1:0]                        o_bresp,
	input  wire logic                         i_arvalid,
	output logic                              o_arready,
	input  wire logic [7:0]                   i_araddr,
	output logic                              o_rvalid,
	input  wire logic                         i_rready,
	output logic [31:0]                       o_rdata,
	output logic [1:0]                        o_rresp,
	input  wire logic                         i_lvd_rst,
	input  wire logic                         i_illop_rst,
	input  wire logic                         i_clk_loss_rst,
	input  wire logic                         i_dbg_rst,
	input  wire logic                         i_bdm_active,
	input  wire logic                         i_rst_pin,
	output logic                              o_rst_pin_o,
	output logic                              o_rst_pin_oe,
	output logic                              o_core_rst,
	output logic                              o_clk_self_mode,
	output logic                              o_io_default,
	input  wire logic [rwie_pkg::IRQ_N-1:0]   i_irq_evt,
	input  wire rwie_pkg::rwie_cpu_regs_s     i_cpu_regs,
	input  wire logic                         i_instr_done,
	input  wire logic                         i_rti_req,
	output rwie_pkg::rwie_cpu_regs_s          o_cpu_regs,
	output logic                              o_cpu_load,
	output logic                              o_cpu_hold,
	output logic [15:0]                       o_mem_addr,
	output logic                              o_mem_re,
	output logic                              o_mem_we,
	output logic [7:0]                        o_mem_wdata,
	input  wire logic [7:0]                   i_mem_rdata,
	output logic [7:0]                        o_queue_byte,
	output logic                              o_queue_wr
);
	import rwie_pkg::*;

	function automatic logic [15:0] addr_off(input logic [15:0] base, input logic [2:0] off);
		addr_off = base + {13'h0, off};
	endfunction

	function automatic logic [1:0] top_idx(input logic [IRQ_N-1:0] p);
		top_idx = 2'h0;
		for (int k = 0; k < IRQ_N; k++) begin
			if (p[k]) begin
				top_idx = 2'(k);
			end
		end
	endfunction

	function automatic logic [7:0] push_byte(input rwie_cpu_regs_s r, input logic [2:0] s);
		unique case (s)
			3'h0: push_byte = r.pc[7:0];
			3'h1: push_byte = r.pc[15:8];
			3'h2: push_byte = r.x;
			3'h3: push_byte = r.a;
			default: push_byte = r.condition_code_reg;
		endcase
	endfunction

	rwie_state_e     st_q;
	rwie_cpu_regs_s  regs_q, cpu_out_q;
	logic [5:0]      cnt_q;
	logic [2:0]      step_q;
	logic            ph_q;
	logic [15:0]     vaddr_q, mem_addr_q;
	logic [7:0]      wdata_q, qbyte_q, srs_q;
	logic            re_q, we_q, qwr_q, load_q, hold_q;
	logic            pin_oe_q, pin_o_q, core_rst_q, self_q, iodef_q;
	logic [2:0]      system_options_reg_q;
	logic [IRQ_N-1:0] flag_q, ien_q;
	logic            irq_req_q;
	logic [17:0]     wd_cnt_q;
	logic            aw_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
	logic [1:0]      bresp_q, rresp_q;
	logic [31:0]     rdata_q;
	logic            wd_fire, rst_go, go_irq, wr_fire, srs_wr, sample_pt, wd_run;
	logic [17:0]     wd_last;

	// ----------------------------------------
	// reset entry and watchdog
	// ----------------------------------------
	assign wr_fire   = aw_rdy_q;
	assign srs_wr    = wr_fire && i_awaddr == ADDR_SRS;
	assign sample_pt = st_q == S_SETTLE && cnt_q == RST_SAMPLE_CYC - 6'h01;
	assign wd_last   = system_options_reg_q[SYSTEM_OPTIONS_REG_TSEL] ? 18'(WD_LONG_CYC - 1) : 18'(WD_SHORT_CYC - 1);
	assign wd_run    = system_options_reg_q[SYSTEM_OPTIONS_REG_EN] && !i_bdm_active && !core_rst_q;
	assign wd_fire   = wd_run && wd_cnt_q == wd_last;
	// sources are ignored while a reset sequence is already running
	assign rst_go = !core_rst_q && (wd_fire || i_lvd_rst || i_illop_rst || i_clk_loss_rst || i_dbg_rst || !i_rst_pin);
	assign go_irq = st_q == S_RUN && !rst_go && !i_rti_req && i_instr_done && irq_req_q;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || core_rst_q || srs_wr) begin
			wd_cnt_q <= 18'h0;
		end else if (wd_run) begin
			wd_cnt_q <= wd_cnt_q + 18'h1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			srs_q <= 8'(1 << SRS_POR);
		end else if (rst_go) begin
			// latest reset replaces older causes; debug reset leaves none
			srs_q <= 8'h00;
			srs_q[SRS_WD]    <= wd_fire;
			srs_q[SRS_LVD]   <= i_lvd_rst;
			srs_q[SRS_ILLOP] <= i_illop_rst;
			srs_q[SRS_CLK]   <= i_clk_loss_rst;
		end else if (sample_pt && !i_rst_pin) begin
			srs_q[SRS_PIN] <= 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || rst_go) begin
			system_options_reg_q <= SYSTEM_OPTIONS_REG_RESET;
		end else if (wr_fire && i_awaddr == ADDR_SYSTEM_OPTIONS_REG && i_wstrb[0] && !system_options_reg_q[SYSTEM_OPTIONS_REG_LOCK]) begin
			system_options_reg_q <= {1'b1, i_wdata[SYSTEM_OPTIONS_REG_TSEL], i_wdata[SYSTEM_OPTIONS_REG_EN]};
		end
	end

	// ----------------------------------------
	// interrupt flags and qualification
	// ----------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || rst_go) begin
			flag_q <= '0;
			ien_q  <= '0;
		end else begin
			// a new event beats a same-cycle clear
			if (wr_fire && i_awaddr == ADDR_IFLAG && i_wstrb[0]) begin
				flag_q <= (flag_q & ~i_wdata[IRQ_N-1:0]) | i_irq_evt;
			end else begin
				flag_q <= flag_q | i_irq_evt;
			end
			if (wr_fire && i_awaddr == ADDR_IEN && i_wstrb[0]) begin
				ien_q <= i_wdata[IRQ_N-1:0];
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			irq_req_q <= 1'b0;
		end else begin
			irq_req_q <= |(flag_q & ien_q) && !i_cpu_regs.condition_code_reg[CCR_I] && !go_irq;
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			st_q <= S_DRIVE;
			cnt_q <= 6'h00;
			step_q <= 3'h0;
			ph_q <= 1'b0;
			regs_q <= '0;
			cpu_out_q <= '0;
			vaddr_q <= VEC_RESET;
			mem_addr_q <= 16'h0000;
			wdata_q <= 8'h00;
			qbyte_q <= 8'h00;
			re_q <= 1'b0;
			we_q <= 1'b0;
			qwr_q <= 1'b0;
			load_q <= 1'b0;
			hold_q <= 1'b1;
			pin_oe_q <= 1'b1;
			core_rst_q <= 1'b1;
			self_q <= 1'b1;
			iodef_q <= 1'b1;
		end else begin
			re_q <= 1'b0;
			we_q <= 1'b0;
			qwr_q <= 1'b0;
			load_q <= 1'b0;
			if (rst_go) begin
				st_q <= S_DRIVE;
				cnt_q <= 6'h00;
				pin_oe_q <= 1'b1;
				core_rst_q <= 1'b1;
				self_q <= 1'b1;
				iodef_q <= 1'b1;
				hold_q <= 1'b1;
			end else begin
				unique case (st_q)
					S_RUN: begin
						if (i_rti_req) begin
							st_q <= S_POP;
							regs_q <= i_cpu_regs;
							step_q <= 3'h0;
							ph_q <= 1'b0;
							hold_q <= 1'b1;
						end else if (go_irq) begin
							st_q <= S_PUSH;
							regs_q <= i_cpu_regs;
							step_q <= 3'h0;
							hold_q <= 1'b1;
							vaddr_q <= IRQ_VEC_TOP - {13'h0, top_idx(flag_q & ien_q), 1'b0};
						end
					end
					S_DRIVE: begin
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q == RST_DRIVE_CYC - 6'h01) begin
							pin_oe_q <= 1'b0;
							st_q <= S_SETTLE;
							cnt_q <= 6'h00;
						end
					end
					S_SETTLE: begin
						cnt_q <= cnt_q + 6'h01;
						if (sample_pt) begin
							st_q <= S_VEC;
							step_q <= 3'h0;
							ph_q <= 1'b0;
							vaddr_q <= VEC_RESET;
							regs_q <= '0;
							regs_q.sp <= SP_RESET;
							regs_q.condition_code_reg <= CCR_RESET;
						end
					end
					S_PUSH: begin
						we_q <= 1'b1;
						mem_addr_q <= regs_q.sp;
						wdata_q <= push_byte(regs_q, step_q);
						regs_q.sp <= regs_q.sp - 16'h0001;
						step_q <= step_q + 3'h1;
						if (step_q == PUSH_LAST) begin
							regs_q.condition_code_reg[CCR_I] <= 1'b1;
							st_q <= S_VEC;
							step_q <= 3'h0;
							ph_q <= 1'b0;
						end
					end
					S_VEC: begin
						ph_q <= !ph_q;
						if (!ph_q) begin
							re_q <= 1'b1;
							mem_addr_q <= addr_off(vaddr_q, step_q);
						end else begin
							step_q <= step_q + 3'h1;
							if (step_q == VEC_LAST) begin
								regs_q.pc[7:0] <= i_mem_rdata;
								st_q <= S_FILL;
								step_q <= 3'h0;
							end else begin
								regs_q.pc[15:8] <= i_mem_rdata;
							end
						end
					end
					S_FILL: begin
						ph_q <= !ph_q;
						if (!ph_q) begin
							re_q <= 1'b1;
							mem_addr_q <= addr_off(regs_q.pc, step_q);
						end else begin
							qbyte_q <= i_mem_rdata;
							qwr_q <= 1'b1;
							step_q <= step_q + 3'h1;
							if (step_q == FILL_LAST) begin
								st_q <= S_RUN;
								load_q <= 1'b1;
								cpu_out_q <= regs_q;
								hold_q <= 1'b0;
								core_rst_q <= 1'b0;
								self_q <= 1'b0;
								iodef_q <= 1'b0;
							end
						end
					end
					S_POP: begin
						ph_q <= !ph_q;
						if (!ph_q) begin
							re_q <= 1'b1;
							mem_addr_q <= addr_off(regs_q.sp, 3'h1);
						end else begin
							regs_q.sp <= regs_q.sp + 16'h0001;
							step_q <= step_q + 3'h1;
							unique case (step_q)
								3'h0: regs_q.condition_code_reg <= i_mem_rdata;
								3'h1: regs_q.a <= i_mem_rdata;
								3'h2: regs_q.x <= i_mem_rdata;
								3'h3: regs_q.pc[15:8] <= i_mem_rdata;
								default: begin
									regs_q.pc[7:0] <= i_mem_rdata;
									st_q <= S_FILL;
									step_q <= 3'h0;
								end
							endcase
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			aw_rdy_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			aw_rdy_q <= !aw_rdy_q && !bvalid_q && i_awvalid && i_wvalid;
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= (i_awaddr == ADDR_SRS || i_awaddr == ADDR_SYSTEM_OPTIONS_REG || i_awaddr == ADDR_IFLAG
				            || i_awaddr == ADDR_IEN) ? RESP_OKAY : RESP_SLVERR;
			end else if (i_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			ar_rdy_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end else begin
			ar_rdy_q <= !ar_rdy_q && !rvalid_q && i_arvalid;
			if (ar_rdy_q) begin
				rvalid_q <= 1'b1;
				rresp_q <= RESP_OKAY;
				unique case (i_araddr)
					ADDR_SRS:   rdata_q <= {24'h000000, srs_q};
					ADDR_SYSTEM_OPTIONS_REG:  rdata_q <= {29'h0, system_options_reg_q};
					ADDR_IFLAG: rdata_q <= {28'h0000000, flag_q};
					ADDR_IEN:   rdata_q <= {28'h0000000, ien_q};
					default: begin
						rdata_q <= 32'h00000000;
						rresp_q <= RESP_SLVERR;
					end
				endcase
			end else if (i_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// pin only ever pulls low; the level comes from the enable
	always_ff @(posedge i_ref_clk) begin
		pin_o_q <= 1'b0;
	end

	assign o_awready = aw_rdy_q;
	assign o_wready = aw_rdy_q;
	assign o_bvalid = bvalid_q;
	assign o_bresp = bresp_q;
	assign o_arready = ar_rdy_q;
	assign o_rvalid = rvalid_q;
	assign o_rdata = rdata_q;
	assign o_rresp = rresp_q;
	assign o_rst_pin_o = pin_o_q;
	assign o_rst_pin_oe = pin_oe_q;
	assign o_core_rst = core_rst_q;
	assign o_clk_self_mode = self_q;
	assign o_io_default = iodef_q;
	assign o_cpu_regs = cpu_out_q;
	assign o_cpu_load = load_q;
	assign o_cpu_hold = hold_q;
	assign o_mem_addr = mem_addr_q;
	assign o_mem_re = re_q;
	assign o_mem_we = we_q;
	assign o_mem_wdata = wdata_q;
	assign o_queue_byte = qbyte_q;
	assign o_queue_wr = qwr_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	property p_pin_drive;
		$rose(pin_oe_q) |-> ##33 pin_oe_q ##1 !pin_oe_q;
	endproperty
	a_pin_drive: assert property (p_pin_drive) else $error("reset pin drive length wrong");
	property p_pin_sample;
		$fell(pin_oe_q) ##37 (!i_rst_pin && !rst_go) |=> srs_q[SRS_PIN];
	endproperty
	a_pin_sample: assert property (p_pin_sample) else $error("pin cause not recorded");
	property p_wd_restart;
		srs_wr |=> wd_cnt_q == 18'h0 && $stable(srs_q);
	endproperty
	a_wd_restart: assert property (p_wd_restart) else $error("watchdog restart failed");
	property p_wd_period;
		wd_fire |-> wd_cnt_q == wd_last ##1 core_rst_q && srs_q[SRS_WD];
	endproperty
	a_wd_period: assert property (p_wd_period) else $error("watchdog expiry wrong");
	property p_wd_freeze;
		(i_bdm_active && !srs_wr && !rst_go) |=> $stable(wd_cnt_q);
	endproperty
	a_wd_freeze: assert property (p_wd_freeze) else $error("watchdog ran in debug");
	property p_wd_enabled;
		$rose(pin_oe_q) |-> system_options_reg_q == SYSTEM_OPTIONS_REG_RESET;
	endproperty
	a_wd_enabled: assert property (p_wd_enabled) else $error("watchdog not enabled after reset");
	property p_irq_qual;
		(st_q == S_RUN && i_instr_done && !i_rti_req && !rst_go
		 && $past(|(flag_q & ien_q) && !i_cpu_regs.condition_code_reg[CCR_I])) |=> st_q == S_PUSH;
	endproperty
	a_irq_qual: assert property (p_irq_qual) else $error("request not raised");
	property p_push_first;
		go_irq |-> ##2 we_q && wdata_q == $past(i_cpu_regs.pc[7:0], 2) && mem_addr_q == $past(i_cpu_regs.sp, 2);
	endproperty
	a_push_first: assert property (p_push_first) else $error("first stacked byte wrong");
	property p_boot_regs;
		(load_q && $past(core_rst_q)) |-> cpu_out_q.sp == SP_RESET && cpu_out_q.condition_code_reg[CCR_I];
	endproperty
	a_boot_regs: assert property (p_boot_regs) else $error("reset registers wrong");

	c_irq: cover property (go_irq ##[1:40] load_q);
	c_rti: cover property (st_q == S_RUN && i_rti_req ##[1:40] load_q);
	c_wd: cover property (wd_fire);
	c_pin: cover property (sample_pt && !i_rst_pin);
endmodule

// file: verification/reset_watchdog_interrupt_entry_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module reset_watchdog_interrupt_entry_tb_top;
	import rwie_pkg::*;
	// ----------------------------------------
	// short watchdog periods keep the run brief
	// ----------------------------------------
	localparam int unsigned LONG_C  = 64;
	localparam int unsigned SHORT_C = 16;
	logic                 clk, rst, awvalid, wvalid, bready, arvalid, rready, bdm, idone, return_from_interrupt_instr, ext_low;
	logic                 awready, wready, bvalid, arready, rvalid, oe, pin, core_rst, self, iodef;
	logic                 load, hold, mre, mwe, qwr, pin_o, rst_q = 1'b1;
	logic [7:0]           awaddr, araddr, mwdata, mrdata, qbyte, q0;
	logic [15:0]          maddr, v;
	logic [31:0]          wdata, rdata;
	logic [3:0]           wstrb, src;
	logic [1:0]           bresp, rresp;
	logic [IRQ_N-1:0]     evt;
	rwie_cpu_regs_s       cregs, ocregs;
	logic [7:0]           stk [5] = '{8'h34, 8'h12, 8'h11, 8'h22, 8'h00};
	int                   failures = 0, checks = 0, n, b, qn = 0, rst_cnt = 0;

	rwie_top #(.WD_LONG_CYC(LONG_C), .WD_SHORT_CYC(SHORT_C)) i_rwie_top (
		.i_ref_clk(clk), .i_sys_rst(rst), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
		.i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid),
		.i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
		.o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_lvd_rst(src[0]),
		.i_illop_rst(src[1]), .i_clk_loss_rst(src[2]), .i_dbg_rst(src[3]), .i_bdm_active(bdm),
		.i_rst_pin(pin), .o_rst_pin_o(pin_o), .o_rst_pin_oe(oe), .o_core_rst(core_rst), .o_clk_self_mode(self),
		.o_io_default(iodef), .i_irq_evt(evt), .i_cpu_regs(cregs), .i_instr_done(idone), .i_rti_req(return_from_interrupt_instr),
		.o_cpu_regs(ocregs), .o_cpu_load(load), .o_cpu_hold(hold), .o_mem_addr(maddr), .o_mem_re(mre),
		.o_mem_we(mwe), .o_mem_wdata(mwdata), .i_mem_rdata(mrdata), .o_queue_byte(qbyte), .o_queue_wr(qwr)
	);

	rwie_mem_model i_rwie_mem_model (
		.i_ref_clk(clk), .i_addr(maddr), .i_re(mre), .i_we(mwe), .i_wdata(mwdata), .o_rdata(mrdata),
		.i_oe(oe), .i_ext_low(ext_low), .o_pin(pin)
	);

	// ----------------------------------------
	// clock and monitors
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		rst_q <= core_rst;
		if (core_rst && !rst_q) begin
			rst_cnt <= rst_cnt + 1;
		end
		if (qwr) begin
			if (qn == 0) begin
				q0 <= qbyte;
			end
			qn <= qn + 1;
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic stop_test();
		if (failures == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic timeout(input string what);
		failures++;
		$display("BAD %s exp done got timeout", what);
		stop_test();
	endtask

	task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		awaddr  <= ad;
		wdata   <= d;
		bready  <= 1'b1;
		while (bvalid !== 1'b1 && k < 50) begin
			@(posedge clk);
			k++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		if (bvalid !== 1'b1) timeout("write");
		bready <= 1'b0;
		`CHK("bresp", er, bresp)
	endtask

	task automatic rchk(input string nm, input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr  <= ad;
		rready  <= 1'b1;
		while (rvalid !== 1'b1 && k < 50) begin
			@(posedge clk);
			k++;
			if (arready) arvalid <= 1'b0;
		end
		if (rvalid !== 1'b1) timeout("read");
		rready <= 1'b0;
		`CHK(nm, e, rdata)
		`CHK("rresp", er, rresp)
	endtask

	task automatic pulse(input logic [3:0] s, input logic [3:0] e, input logic d, input logic r);
		@(posedge clk);
		src   <= s;
		evt   <= e;
		idone <= d;
		return_from_interrupt_instr   <= r;
		@(posedge clk);
		src   <= 4'h0;
		evt   <= 4'h0;
		idone <= 1'b0;
		return_from_interrupt_instr   <= 1'b0;
	endtask

	task automatic wait_load();
		int k;
		k = 0;
		while (load !== 1'b1 && k < 400) begin
			@(posedge clk);
			k++;
		end
		if (load !== 1'b1) timeout("load");
	endtask

	task automatic cnt_rst(input int mx);
		n = 0;
		while (core_rst !== 1'b1 && n < mx) begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic chk_boot();
		`CHK("pc", ({i_rwie_mem_model.mem[VEC_RESET], i_rwie_mem_model.mem[VEC_RESET + 16'h1]}), ocregs.pc)
		`CHK("sp", SP_RESET, ocregs.sp)
		`CHK("ccr", CCR_RESET, ocregs.condition_code_reg)
		`CHK("xa", 16'h0, {ocregs.x, ocregs.a})
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		{rst, awvalid, wvalid, bready, arvalid, rready, bdm, idone, return_from_interrupt_instr, ext_low} = 10'h200;
		{awaddr, araddr, wdata, src, evt} = '0;
		wstrb = 4'hF;
		cregs = '0;
		repeat (4) @(posedge clk);
		`CHK("por_oe", 1'b1, oe)
		`CHK("pin_o", 1'b0, pin_o)
		rst <= 1'b0;
		wait_load();
		chk_boot();
		rchk("srs_por", ADDR_SRS, 32'h1 << SRS_POR, RESP_OKAY);
		rchk("system_options_reg_rst", ADDR_SYSTEM_OPTIONS_REG, 32'(SYSTEM_OPTIONS_REG_RESET), RESP_OKAY);
		rchk("unmapped", 8'h10, 32'h0, RESP_SLVERR);
		axw(ADDR_SRS, 32'hFF, RESP_OKAY);
		cnt_rst(LONG_C + 20);
		`CHK("wd_long", 1'b1, n >= LONG_C - 4 && n <= LONG_C + 2)
		wait_load();
		rchk("srs_wd", ADDR_SRS, 32'h1 << SRS_WD, RESP_OKAY);
		rchk("system_options_reg_wd", ADDR_SYSTEM_OPTIONS_REG, 32'(SYSTEM_OPTIONS_REG_RESET), RESP_OKAY);
		b = rst_cnt;
		repeat (5) begin
			repeat (40) @(posedge clk);
			axw(ADDR_SRS, 32'h0, RESP_OKAY);
		end
		`CHK("no_wd", b, rst_cnt)
		rchk("srs_kept", ADDR_SRS, 32'h1 << SRS_WD, RESP_OKAY);
		axw(ADDR_SYSTEM_OPTIONS_REG, 32'h0, RESP_OKAY);
		axw(ADDR_SYSTEM_OPTIONS_REG, 32'h3, RESP_OKAY);
		rchk("system_options_reg_lock", ADDR_SYSTEM_OPTIONS_REG, 32'h1 << SYSTEM_OPTIONS_REG_LOCK, RESP_OKAY);
		repeat (150) @(posedge clk);
		`CHK("wd_off", b, rst_cnt)
		// internal sources; pin held low only across the late sample
		for (int k = 0; k < 3; k++) begin
			pulse(4'h1 << k, 4'h0, 1'b0, 1'b0);
			cnt_rst(10);
			`CHK("self", 1'b1, self)
			`CHK("iodef", 1'b1, iodef)
			n = 0;
			while (oe === 1'b1 && n < 100) begin
				n++;
				@(posedge clk);
			end
			`CHK("drive_len", int'(RST_DRIVE_CYC), n)
			if (k == 0) begin
				repeat (35) @(posedge clk);
				ext_low <= 1'b1;
				repeat (3) @(posedge clk);
				ext_low <= 1'b0;
			end
			wait_load();
			chk_boot();
			rchk("srs_src", ADDR_SRS, (32'h1 << (k == 0 ? SRS_LVD : k == 1 ? SRS_ILLOP : SRS_CLK))
				| (k == 0 ? 32'h1 << SRS_PIN : 32'h0), RESP_OKAY);
			axw(ADDR_SYSTEM_OPTIONS_REG, k == 2 ? 32'h1 : 32'h0, RESP_OKAY);
			axw(ADDR_SRS, 32'h0, RESP_OKAY);
		end
		cnt_rst(SHORT_C + 20);
		`CHK("wd_short", 1'b1, n >= SHORT_C - 4 && n <= SHORT_C + 2)
		wait_load();
		bdm <= 1'b1;
		b = rst_cnt;
		repeat (200) @(posedge clk);
		`CHK("wd_bdm", b, rst_cnt)
		bdm <= 1'b0;
		cnt_rst(LONG_C + 4);
		`CHK("wd_resume", 1'b1, core_rst)
		wait_load();
		pulse(4'h8, 4'h0, 1'b0, 1'b0);
		cnt_rst(10);
		wait_load();
		rchk("srs_dbg", ADDR_SRS, 32'h0, RESP_OKAY);
		axw(ADDR_SYSTEM_OPTIONS_REG, 32'h0, RESP_OKAY);
		// two pending sources, higher one must win
		cregs <= '{16'h1234, 16'h00F0, 8'h11, 8'h22, 8'h00};
		wstrb <= 4'h0;
		axw(ADDR_IEN, 32'hF, RESP_OKAY);
		wstrb <= 4'hF;
		rchk("ien_strb", ADDR_IEN, 32'h0, RESP_OKAY);
		axw(ADDR_IEN, 32'hA, RESP_OKAY);
		pulse(4'h0, 4'hA, 1'b0, 1'b0);
		rchk("iflag", ADDR_IFLAG, 32'hA, RESP_OKAY);
		b = i_rwie_mem_model.wr_cnt;
		repeat (10) @(posedge clk);
		`CHK("early_hold", 1'b0, hold)
		qn <= 0;
		pulse(4'h0, 4'h0, 1'b1, 1'b0);
		wait_load();
		for (int i = 0; i < 5; i++) begin
			`CHK("stack", stk[i], i_rwie_mem_model.mem[16'h00F0 - i])
		end
		`CHK("stk_n", b + 5, i_rwie_mem_model.wr_cnt)
		`CHK("sp_in", 16'h00EB, ocregs.sp)
		`CHK("i_set", 1'b1, ocregs.condition_code_reg[CCR_I])
		v = {i_rwie_mem_model.mem[IRQ_VEC_TOP - 16'h6], i_rwie_mem_model.mem[IRQ_VEC_TOP - 16'h5]};
		`CHK("vec", v, ocregs.pc)
		@(posedge clk);
		`CHK("q_n", 3, qn)
		`CHK("q0", i_rwie_mem_model.mem[v], q0)
		axw(ADDR_IFLAG, 32'hF, RESP_OKAY);
		rchk("iflag_clr", ADDR_IFLAG, 32'h0, RESP_OKAY);
		cregs.sp <= 16'h00EB;
		qn <= 0;
		pulse(4'h0, 4'h0, 1'b0, 1'b1);
		wait_load();
		`CHK("rti_regs", ({16'h1234, 16'h00F0, 8'h11, 8'h22, 8'h00}), ocregs)
		@(posedge clk);
		`CHK("q_rti", 3, qn)
		// mask set: flag pends but no entry
		cregs.condition_code_reg <= CCR_RESET;
		b = i_rwie_mem_model.wr_cnt;
		pulse(4'h0, 4'h2, 1'b0, 1'b0);
		repeat (3) @(posedge clk);
		pulse(4'h0, 4'h0, 1'b1, 1'b0);
		repeat (20) @(posedge clk);
		`CHK("masked", b, i_rwie_mem_model.wr_cnt)
		`CHK("masked_hold", 1'b0, hold)
		stop_test();
	end
endmodule

// file: verification/rwie_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// far side: cpu memory and reset pad
// ----------------------------------------
module rwie_mem_model (
	input  wire logic        i_ref_clk,
	input  wire logic [15:0] i_addr,
	input  wire logic        i_re,
	input  wire logic        i_we,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata,
	input  wire logic        i_oe,
	input  wire logic        i_ext_low,
	output logic             o_pin
);
	logic [7:0] mem [0:65535];
	int         wr_cnt;

	initial begin
		wr_cnt = 0;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'hA5;
		end
	end

	// stale data inverted, so a late sample never matches by luck
	assign o_rdata = i_re ? mem[i_addr] : ~mem[i_addr];

	always @(posedge i_ref_clk) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
			wr_cnt      <= wr_cnt + 1;
		end
	end

	// internal pullup unless device or outside pulls low
	assign o_pin = (i_oe || i_ext_low) ? 1'b0 : 1'b1;
endmodule
